// ### src/cmpc_pkg.sv
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package cmpc_pkg;

  // register byte offsets
  localparam logic [7:0] CMPC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] CMPC_OFS_STAT   = 8'h04;
  localparam logic [7:0] CMPC_OFS_CLR    = 8'h08;
  localparam logic [7:0] CMPC_OFS_IEN    = 8'h0C;
  localparam logic [7:0] CMPC_OFS_SYS    = 8'h10;

  // control register fields
  localparam int CMPC_BIT_ENABLE  = 7;
  localparam int CMPC_BIT_RESULT  = 6;
  localparam int CMPC_BIT_PINDRV  = 5;
  localparam int CMPC_BIT_INVERT  = 4;
  localparam int CMPC_BIT_REFSEL  = 2;
  localparam int CMPC_BIT_NEGSEL  = 0;
  localparam logic [7:0] CMPC_CTRL_WMASK = 8'hB7;
  localparam logic [7:0] CMPC_CTRL_RST   = 8'h00;

  // irq status/clear/enable layout
  localparam int CMPC_BIT_EV_CHANGE = 0;

  // system register fields
  localparam int CMPC_BIT_PERIPH_IE = 0;
  localparam int CMPC_BIT_GLOBAL_IE = 1;
  localparam int CMPC_BIT_PIN_DIR   = 2;
  localparam logic [2:0] CMPC_SYS_RST = 3'h4;

  // synchroniser depth ahead of the change detector
  localparam int CMPC_SYNC_STAGES = 2;

  // ahb transfer type
  localparam logic [1:0] CMPC_HTRANS_NONSEQ = 2'h2;

endpackage

// ### src/cmpc_sync_if.sv
`timescale 1ns/1ps
interface cmpc_sync_if;
  logic raw_decision;
  logic active;
  logic decision;
  logic changed;

  modport ctrl
  (
    output raw_decision,
    output active,
    input  decision,
    input  changed
  );

  modport sync
  (
    input  raw_decision,
    input  active,
    output decision,
    output changed
  );
endinterface

// ### src/cmpc_sync.sv
`timescale 1ns/1ps
module cmpc_sync
  import cmpc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // carrier to the control logic
  cmpc_sync_if.sync sif
);

  logic [CMPC_SYNC_STAGES-1:0] stage_r;
  logic                        prev_r;

  //----------------------------------------------------------------------
  // synchroniser chain
  //----------------------------------------------------------------------
  // first stage is read only by the second; analog edge is asynchronous
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stage_r <= '0;
    else
      stage_r <= {stage_r[CMPC_SYNC_STAGES-2:0], sif.raw_decision};
  end

  // previous synced value for the change detector
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev_r <= 1'b0;
    else
      prev_r <= stage_r[CMPC_SYNC_STAGES-1];
  end

  // decision forced low while off so a dead core reads a stable zero
  assign sif.decision = sif.active & stage_r[CMPC_SYNC_STAGES-1];
  assign sif.changed  = sif.active & (stage_r[CMPC_SYNC_STAGES-1] ^ prev_r);

endmodule

// ### src/cmpc_top.sv
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module cmpc_top
  import cmpc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // analog comparator core
  input  wire logic        raw_decision,
  output logic             cmp_power_en,
  output logic             cmp_one_ref_select,
  output logic [1:0]       cmp_one_neg_select,
  // comparator output pin
  output logic             pin_out,
  output logic             pin_oe_n,
  // cpu sleep and interrupt
  input  wire logic        sleep_mode,
  output logic             irq,
  output logic             wake_req,
  output logic             isr_req
);

  cmpc_sync_if sif ();

  logic [7:0]  ctrl_r;
  logic [2:0]  sys_r;
  logic        stat_r;
  logic        ien_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  logic        pin_out_r;
  logic        pin_oe_n_r;
  logic        wake_r;
  logic        awake_r;
  logic        addr_ok;
  logic        do_wr;
  logic        result;
  logic        drive_ok;
  logic [31:0] rd_mux;

  //----------------------------------------------------------------------
  // field decode
  //----------------------------------------------------------------------
  logic cmp_one_enable;
  logic cmp_one_pin_drive;
  logic cmp_one_invert;
  logic peripheral_irq_enable;
  logic global_irq_enable;
  logic pin_direction_bit;

  // named views of the control and system registers
  assign cmp_one_enable        = ctrl_r[CMPC_BIT_ENABLE];
  assign cmp_one_pin_drive     = ctrl_r[CMPC_BIT_PINDRV];
  assign cmp_one_invert        = ctrl_r[CMPC_BIT_INVERT];
  assign peripheral_irq_enable = sys_r[CMPC_BIT_PERIPH_IE];
  assign global_irq_enable     = sys_r[CMPC_BIT_GLOBAL_IE];
  assign pin_direction_bit     = sys_r[CMPC_BIT_PIN_DIR];

  //----------------------------------------------------------------------
  // analog core control
  //----------------------------------------------------------------------
  // sleep_mode never gates the core: an enabled core keeps running asleep
  assign cmp_power_en       = cmp_one_enable;
  assign cmp_one_ref_select = ctrl_r[CMPC_BIT_REFSEL];
  assign cmp_one_neg_select = ctrl_r[CMPC_BIT_NEGSEL+1:CMPC_BIT_NEGSEL];

  // carrier to the synchroniser
  assign sif.raw_decision = raw_decision;
  assign sif.active       = cmp_one_enable;

  cmpc_sync u_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .sif  (sif)
  );

  // polarity applied after synchronisation
  assign result = sif.decision ^ cmp_one_invert;

  //----------------------------------------------------------------------
  // ahb-lite slave
  //----------------------------------------------------------------------
  // zero wait states, always okay; unmapped reads give zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  assign addr_ok = hsel & hready & htrans[1];
  assign do_wr   = wr_pend_r;

  // read mux, result bit comes live from the synced result
  always_comb
  begin
    rd_mux = '0;
    unique case (haddr)
      CMPC_OFS_CTRL:
      begin
        rd_mux[7:0]            = ctrl_r & CMPC_CTRL_WMASK;
        rd_mux[CMPC_BIT_RESULT] = result;
      end
      CMPC_OFS_STAT: rd_mux[CMPC_BIT_EV_CHANGE] = stat_r;
      CMPC_OFS_IEN:  rd_mux[CMPC_BIT_EV_CHANGE] = ien_r;
      CMPC_OFS_SYS:  rd_mux[2:0] = sys_r;
      default:       rd_mux = '0;
    endcase
  end

  // address phase capture for writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      if (hready)
      begin
        wr_pend_r <= addr_ok & hwrite;
        wr_addr_r <= haddr;
      end
    end
  end

  // read data registered at the address phase, stands for the data phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hrdata_r <= '0;
    else if (addr_ok & ~hwrite)
      hrdata_r <= rd_mux;
  end

  //----------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------
  // control: result and bit 3 are not storable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_r <= CMPC_CTRL_RST;
    else if (do_wr && wr_addr_r == CMPC_OFS_CTRL)
      ctrl_r <= hwdata[7:0] & CMPC_CTRL_WMASK;
  end

  // system bits: irq gates and pin direction, pin is input after reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sys_r <= CMPC_SYS_RST;
    else if (do_wr && wr_addr_r == CMPC_OFS_SYS)
      sys_r <= hwdata[2:0];
  end

  // interrupt enable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ien_r <= 1'b0;
    else if (do_wr && wr_addr_r == CMPC_OFS_IEN)
      ien_r <= hwdata[CMPC_BIT_EV_CHANGE];
  end

  // sticky change flag; a new change wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stat_r <= 1'b0;
    else if (sif.changed)
      stat_r <= 1'b1;
    else if (do_wr && wr_addr_r == CMPC_OFS_CLR && hwdata[CMPC_BIT_EV_CHANGE])
      stat_r <= 1'b0;
  end

  //----------------------------------------------------------------------
  // output pin
  //----------------------------------------------------------------------
  assign drive_ok = cmp_one_pin_drive & cmp_one_enable & ~pin_direction_bit;

  // registered so the pin never glitches on a decode hazard
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out_r  <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end
    else
    begin
      pin_out_r  <= drive_ok & result;
      pin_oe_n_r <= ~drive_ok;
    end
  end

  assign pin_out  = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;

  //----------------------------------------------------------------------
  // interrupt, wake and vector
  //----------------------------------------------------------------------
  assign irq = stat_r & ien_r;

  // wake pulse every other cycle while a qualified request stands in sleep
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wake_r <= 1'b0;
    else
      wake_r <= sleep_mode & irq & peripheral_irq_enable & ~wake_r;
  end

  // one cycle awake before vectoring, so the next instruction runs first
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      awake_r <= 1'b0;
    else
      awake_r <= ~sleep_mode;
  end

  assign wake_req = wake_r;
  assign isr_req  = irq & peripheral_irq_enable & global_irq_enable
                  & ~sleep_mode & awake_r;

endmodule

// ### dv/cmpc_asserts.sv
`timescale 1ns/1ps
module cmpc_checker
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched outputs and sleep input
  input wire logic cmp_power_en,
  input wire logic pin_oe_n,
  input wire logic sleep_mode,
  input wire logic irq,
  input wire logic wake_req,
  input wire logic isr_req
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_pin_needs_on: assert property (!pin_oe_n |-> $past(cmp_power_en))
    else $error("pin driven by a comparator that was off");
  a_off_pin_free: assert property (!cmp_power_en |=> pin_oe_n)
    else $error("pin still driven after power off");
  a_wake_in_sleep: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request while awake");
  a_wake_from_irq: assert property (wake_req |-> $past(irq))
    else $error("wake request without pending event");
  a_wake_one_cycle: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  a_isr_after_wake: assert property (isr_req |-> !sleep_mode && !$past(sleep_mode))
    else $error("service request before one awake cycle");
  a_isr_from_irq: assert property (isr_req |-> irq)
    else $error("service request without interrupt");
  a_reset_quiet: assert property ($rose(nrst) |-> !cmp_power_en && pin_oe_n && !irq)
    else $error("outputs active right after reset");
endmodule

// attach to every instance of the top module
bind cmpc_top cmpc_checker chk_u
(
  .clk          (clk),
  .nrst         (nrst),
  .cmp_power_en (cmp_power_en),
  .pin_oe_n     (pin_oe_n),
  .sleep_mode   (sleep_mode),
  .irq          (irq),
  .wake_req     (wake_req),
  .isr_req      (isr_req)
);

// ### dv/cmpc_analog_model.sv
`timescale 1ns/1ps
module cmpc_analog_model
(
  // clock for the idle pattern
  input  wire logic        clk,
  // settings from the control logic
  input  wire logic        power_en,
  input  wire logic        ref_select,
  input  wire logic [1:0]  neg_select,
  // analog levels as codes
  input  wire logic [7:0]  pos_level,
  input  wire logic [7:0]  ref_level,
  input  wire logic [31:0] neg_levels,
  // decision to the control logic
  output logic             raw_decision
);
  logic       idle_r = 1'b0;
  logic [7:0] pos_v;
  logic [7:0] neg_v;

  // a powered-down core has no valid decision, so it must not look steady
  always @(posedge clk)
  begin
    idle_r <= !idle_r;
  end

  // input muxes and the compare itself
  assign pos_v        = ref_select ? ref_level : pos_level;
  assign neg_v        = neg_levels[{neg_select, 3'b000} +: 8];
  assign raw_decision = power_en ? (pos_v > neg_v) : idle_r;
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  import cmpc_pkg::*;
  logic        clk, nrst, hsel, hwrite, sleep_mode, raw_decision;
  logic        hready, hreadyout, hresp, cmp_power_en, ref_sel;
  logic        pin_out, pin_oe_n, irq, wake_req, isr_req;
  logic [1:0]  htrans, neg_sel;
  logic [7:0]  haddr, pos_lvl, ref_lvl;
  logic [31:0] hwdata, hrdata, rdat, neg_lvls;
  int          err_count, samples_checked;

  // ----------------------------------------
  // design, analog partner, clock
  // ----------------------------------------
  assign hready = hreadyout;
  cmpc_top dut_u (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .raw_decision(raw_decision), .cmp_power_en(cmp_power_en),
    .cmp_one_ref_select(ref_sel), .cmp_one_neg_select(neg_sel), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .sleep_mode(sleep_mode), .irq(irq), .wake_req(wake_req),
    .isr_req(isr_req));
  cmpc_analog_model model_u (.clk(clk), .power_en(cmp_power_en), .ref_select(ref_sel),
    .neg_select(neg_sel), .pos_level(pos_lvl), .ref_level(ref_lvl), .neg_levels(neg_lvls),
    .raw_decision(raw_decision));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task print_verdict;
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic sig(input int k);
    return (k == 0) ? hreadyout : (k == 1) ? wake_req : isr_req;
  endfunction

  // bounded wait; a hang ends the run as a failure
  task automatic wait_on(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sig(k) !== 1'b1 && n < 30);
    if (sig(k) !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  // one ahb single transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= CMPC_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    wait_on(0);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(0);
    rdat = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {nrst, hsel, hwrite, sleep_mode, htrans, haddr, hwdata} = '0;
    {err_count, samples_checked} = '0;
    pos_lvl  = 8'h80;
    ref_lvl  = 8'hE0;
    neg_lvls = 32'hC832_C832;  // pins 0 and 2 below the positive pin, 1 and 3 above
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(CMPC_OFS_CTRL, 32'h0);
    rd(CMPC_OFS_SYS, 32'h4);
    rd(8'h20, 32'h0);
    wr(CMPC_OFS_CTRL, 32'hFF);
    repeat (3) @(posedge clk);
    rd(CMPC_OFS_CTRL, 32'hB7);
    chk({29'h0, ref_sel, neg_sel}, 32'h7);
    for (int c = 0; c < 4; c++)
    begin
      wr(CMPC_OFS_CTRL, 32'h80 | c);
      repeat (3) @(posedge clk);
      rd(CMPC_OFS_CTRL, {24'h0, 1'b1, ~c[0], 4'h0, c[1:0]});
    end
    wr(CMPC_OFS_CTRL, 32'h90);
    repeat (3) @(posedge clk);
    rd(CMPC_OFS_CTRL, 32'h90);
    wr(CMPC_OFS_SYS, 32'h0);
    wr(CMPC_OFS_CTRL, 32'hA0);
    repeat (3) @(posedge clk);
    chk({30'h0, pin_oe_n, pin_out}, 32'h1);
    wr(CMPC_OFS_SYS, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, pin_oe_n}, 32'h1);
    wr(CMPC_OFS_SYS, 32'h0);
    wr(CMPC_OFS_CTRL, 32'h20);
    repeat (2) @(posedge clk);
    chk({30'h0, pin_oe_n, cmp_power_en}, 32'h2);
    wr(CMPC_OFS_CTRL, 32'h80);
    repeat (2) @(posedge clk);
    chk({31'h0, pin_oe_n}, 32'h1);
    wr(CMPC_OFS_CLR, 32'h1);
    rd(CMPC_OFS_STAT, 32'h0);
    wr(CMPC_OFS_IEN, 32'h1);
    wr(CMPC_OFS_SYS, 32'h5);
    sleep_mode <= 1'b1;
    neg_lvls   <= 32'hC832_C8C8;
    wait_on(1);
    rd(CMPC_OFS_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, isr_req, hresp}, 32'h0);
    wr(CMPC_OFS_CLR, 32'h1);
    rd(CMPC_OFS_STAT, 32'h0);
    wr(CMPC_OFS_IEN, 32'h0);
    neg_lvls <= 32'hC832_C832;
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(CMPC_OFS_STAT, 32'h1);
    wr(CMPC_OFS_IEN, 32'h1);
    wr(CMPC_OFS_SYS, 32'h7);
    wr(CMPC_OFS_CLR, 32'h1);
    neg_lvls <= 32'hC832_C8C8;
    wait_on(2);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(CMPC_OFS_CTRL, 32'h0);
    chk({30'h0, cmp_power_en, pin_oe_n}, 32'h1);
    print_verdict();
  end
endmodule
